/* pkg/pesd_consts.vh */
`ifndef PESD_CONSTS_VH
`define PESD_CONSTS_VH
// Register byte offsets
`define PESD_OFF_EVSEL0 8'h00
`define PESD_OFF_EVSEL1 8'h04
`define PESD_OFF_CNT0 8'h08
`define PESD_OFF_CNT1 8'h0C
`define PESD_OFF_STAT 8'h10
// Event select fields and reset
`define PESD_SEL_EDGE 22
`define PESD_SEL_EN 23
`define PESD_SEL_WMASK 32'h00C0FFFF
`define PESD_SEL_RST 32'h00000000
`define PESD_CNT_RST 32'h00000000
// Event codes
`define PESD_EV_PSTATE 8'h58
`define PESD_EV_THERM 8'h59
`define PESD_EV_ACTIVE 8'h79
`define PESD_EV_BR_FIRST 8'h88
`define PESD_EV_BR_LAST 8'h94
`define PESD_EV_PACKED_INT 8'hCE
`define PESD_EV_SYNC_UOP 8'hD3
`define PESD_EV_TOTAL_UOP 8'hD7
`define PESD_EV_VEC_RET 8'hD8
`define PESD_EV_VEC_COMP 8'hD9
`define PESD_EV_FUSED 8'hDA
`define PESD_EV_UNFUSE 8'hDB
`define PESD_EV_PF_UP 8'hF0
`define PESD_EV_PF_DN 8'hF8
`define PESD_EV_L2_ALLOC 8'h24
`define PESD_EV_L2_EVICT 8'h26
`define PESD_EV_L2_DEVICT 8'h27
`define PESD_EV_L2_FETCH 8'h28
`define PESD_EV_L2_LOAD 8'h29
`define PESD_EV_MEM_REF 8'h43
`define PESD_EV_L1_ALLOC 8'h45
`define PESD_EV_L1_DALLOC 8'h46
`define PESD_EV_L1_DEVICT 8'h47
`define PESD_EV_L1_PEND 8'h48
`define PESD_EV_FETCH 8'h80
`define PESD_EV_FETCH_MISS 8'h81
`define PESD_EV_ITRANS_MISS 8'h85
`define PESD_EV_FETCH_STALL 8'h86
`define PESD_EV_LDEC_STALL 8'h87
// Unit mask values
`define PESD_MASK_ALL 8'h00
`define PESD_MASK_FREQ 8'h02
`define PESD_MASK_MESI 8'h0F
`endif

/* rtl/pesd_evsel.v */
`timescale 1ns/1ps
`include "pesd_consts.vh"
// One event select register; only writable bits are stored
module pesd_evsel #(
  parameter [31:0] WMASK = `PESD_SEL_WMASK
) (
  input wire pclk, // Core clock
  input wire presetn, // Async reset, active low
  input wire wr_en, // Write strobe, one cycle
  input wire [31:0] wr_data, // Write data
  output reg [31:0] sel_reg // Stored selection
);
  // Register update; unwritable bits stay zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= `PESD_SEL_RST;
    end else if (wr_en) begin
      sel_reg <= wr_data & WMASK;
    end
  end
endmodule // pesd_evsel

/* rtl/pesd_counter.v */
`timescale 1ns/1ps
// Accumulating counter with optional rising-edge mode
module pesd_counter #(
  parameter W = 32
) (
  input wire pclk, // Core clock
  input wire presetn, // Async reset, active low
  input wire cnt_en, // Counting enabled
  input wire edge_mode, // Count condition entries only
  input wire [3:0] inc, // Occurrences this cycle
  input wire wr_en, // Software load strobe
  input wire [W-1:0] wr_data, // Load value
  output reg [W-1:0] cnt_reg // Counter value
);
  reg prev_reg; // Condition seen last cycle
  wire active = |inc; // Condition present now
  wire [W-1:0] step = edge_mode ? {{(W-1){1'b0}}, active & ~prev_reg}
                                : {{(W-4){1'b0}}, inc};
  // Edge memory follows the condition while enabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= cnt_en & active;
    end
  end
  // Software load beats counting; the cycle's count is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {W{1'b0}};
    end else if (wr_en) begin
      cnt_reg <= wr_data;
    end else if (cnt_en) begin
      cnt_reg <= cnt_reg + step;
    end
  end
endmodule // pesd_counter

/* rtl/pesd_top.v */
`timescale 1ns/1ps
`include "pesd_consts.vh"
// Performance event selection and two counters behind APB
module pesd_top (
  input wire pclk, // Core clock, 50 MHz
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped access
  input wire pstate_trans, // Performance-state transition pulse
  input wire pstate_freq, // That transition changes frequency
  input wire thermal_trip, // Level: in thermal trip
  input wire core_halted, // Level: core halted
  input wire [12:0] br_ev, // Branch event pulses, codes 88H..94H
  input wire packed_int_ret, // Packed integer instruction retired
  input wire sync_uop, // Synchronisation micro-op
  input wire [1:0] uop_cnt, // Micro-ops this cycle
  input wire [1:0] fused_ret, // Fused retired: 0 load+op, 1 store
  input wire unfusion, // Fused micro-op split in reorder buffer
  input wire [3:0] vec_ret, // Vector retired: PS, SS, PD, SD
  input wire [3:0] vec_comp, // Computational vector retired
  input wire pf_up, // Ascending prefetch issued
  input wire pf_dn, // Descending prefetch issued
  input wire l2_load, // Second level load received
  input wire l2_load_excl, // Load is locked, I/O, UC or WT
  input wire l2_alloc, // Second level line allocated
  input wire l2_evict, // Second level line evicted
  input wire l2_dirty_evict, // Second level dirty line evicted
  input wire [3:0] l2_state, // Line state one-hot: I, S, E, M
  input wire l2_hwpf, // Line came from hardware prefetch
  input wire l2_fetch, // Second level instruction fetch
  input wire l2_fetch_uc, // That fetch is uncacheable
  input wire l2_fetch_tmiss, // That fetch is a translation miss
  input wire [1:0] mem_ref_cnt, // Memory accesses performed
  input wire mem_ref_fp80, // Accesses are 80-bit float
  input wire mem_ref_io, // Accesses are I/O or non-memory
  input wire l1_alloc, // First level line allocated
  input wire l1_dirty_alloc, // First level dirty line allocated
  input wire l1_dirty_evict, // First level dirty line evicted
  input wire [3:0] l1_miss_pend, // Outstanding cacheable misses
  input wire fetch, // Instruction fetch
  input wire fetch_miss, // Fetch missed the fetch unit
  input wire itrans_miss, // Instruction translation miss
  input wire fetch_stall, // Fetch stalled this cycle
  input wire ldec_stall, // Length decoder stalled this cycle
  output wire [31:0] cnt0, // Counter 0 value, registered
  output wire [31:0] cnt1 // Counter 1 value, registered
);

  // Number of counters
  localparam NCNT = 2;

  // Second level qualifier, shared by four events
  // Line state enable bits, then prefetch origin in bits 5:4
  function l2_qual;
    input [7:0] m; // Unit mask
    input [3:0] st; // One-hot line state
    input pf; // From hardware prefetch
    begin
      l2_qual = (|(m[3:0] & st)) &
                ((m[5:4] == 2'b00) ? ~pf :
                 (m[5:4] == 2'b01) ? pf : 1'b1);
    end
  endfunction

  // Widen a single bit to an increment
  function [3:0] one;
    input b; // Event bit
    begin
      one = {3'h0, b};
    end
  endfunction

  // APB phase signals
  wire setup_acc = psel & penable & ~pready; // First access cycle
  wire fire = psel & penable & pready; // Completing edge
  wire aligned = (paddr[1:0] == 2'b00); // Word aligned

  // Flat views of per-counter state
  wire [32*NCNT-1:0] sel_all; // Select registers
  wire [32*NCNT-1:0] cnt_all; // Counter values
  wire [4*NCNT-1:0] inc_all; // Per-cycle increments
  wire [NCNT-1:0] unl_all; // Unlisted code selected

  assign cnt0 = cnt_all[31:0];
  assign cnt1 = cnt_all[63:32];

  // Status: live activity and unlisted selections
  reg [NCNT-1:0] act_reg; // Counter saw an event last cycle
  reg [NCNT-1:0] unl_reg; // Select holds an unlisted code

  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
      wire [7:0] code = sel_all[32*g+7:32*g]; // Event code
      wire [7:0] m = sel_all[32*g+15:32*g+8]; // Unit mask
      wire edge_b = sel_all[32*g+`PESD_SEL_EDGE]; // Edge mode
      wire en_b = sel_all[32*g+`PESD_SEL_EN]; // Counting on
      // Offsets worked out at full width, then cut to the bus width on purpose
      localparam [31:0] SEL_ADDR = `PESD_OFF_EVSEL0 + 4 * g; // Select offset
      localparam [31:0] CNT_ADDR = `PESD_OFF_CNT0 + 4 * g; // Counter offset
      wire [7:0] off_sel = SEL_ADDR[7:0]; // Select byte address
      wire [7:0] off_cnt = CNT_ADDR[7:0]; // Counter byte address
      wire [7:0] br_idx = code - `PESD_EV_BR_FIRST; // Branch index
      reg [3:0] inc; // Increment for this cycle
      reg unl; // No such code

      // Event decode, compared against the select every clock
      always @* begin
        inc = 4'h0;
        unl = 1'b0;
        case (code)
          `PESD_EV_PSTATE: begin
            // All transitions, or only frequency ones
            if (m == `PESD_MASK_ALL) begin
              inc = one(pstate_trans);
            end else if (m == `PESD_MASK_FREQ) begin
              inc = one(pstate_trans & pstate_freq);
            end
          end
          `PESD_EV_THERM: begin
            // Duration; the counter makes entries in edge mode
            inc = one(thermal_trip);
          end
          `PESD_EV_ACTIVE: begin
            inc = one(~core_halted & ~thermal_trip);
          end
          `PESD_EV_PACKED_INT: begin
            inc = one(packed_int_ret);
          end
          `PESD_EV_SYNC_UOP: begin
            inc = one(sync_uop);
          end
          `PESD_EV_TOTAL_UOP: begin
            inc = {2'h0, uop_cnt};
          end
          `PESD_EV_FUSED: begin
            // Mask 0 both kinds, 1 load+op, 2 store pairs
            case (m)
              8'h00: inc = one(fused_ret[0]) + one(fused_ret[1]);
              8'h01: inc = one(fused_ret[0]);
              8'h02: inc = one(fused_ret[1]);
              default: inc = 4'h0;
            endcase
          end
          `PESD_EV_UNFUSE: begin
            inc = one(unfusion);
          end
          `PESD_EV_VEC_RET: begin
            // Mask 0 merges packed and scalar single
            case (m)
              8'h00: inc = one(vec_ret[0]) + one(vec_ret[1]);
              8'h01: inc = one(vec_ret[1]);
              8'h02: inc = one(vec_ret[2]);
              8'h03: inc = one(vec_ret[3]);
              default: inc = 4'h0;
            endcase
          end
          `PESD_EV_VEC_COMP: begin
            // Mask picks one class directly
            if (m[7:2] == 6'h00) begin
              inc = one(vec_comp[m[1:0]]);
            end
          end
          `PESD_EV_PF_UP: begin
            inc = one(pf_up);
          end
          `PESD_EV_PF_DN: begin
            inc = one(pf_dn);
          end
          `PESD_EV_L2_ALLOC: begin
            inc = one(l2_alloc & l2_qual(m, l2_state, l2_hwpf));
          end
          `PESD_EV_L2_EVICT: begin
            inc = one(l2_evict & l2_qual(m, l2_state, l2_hwpf));
          end
          `PESD_EV_L2_DEVICT: begin
            inc = one(l2_dirty_evict & l2_qual(m, l2_state, l2_hwpf));
          end
          `PESD_EV_L2_LOAD: begin
            // Locked, I/O, UC and WT loads never count
            inc = one(l2_load & ~l2_load_excl &
                      l2_qual(m, l2_state, l2_hwpf));
          end
          `PESD_EV_L2_FETCH: begin
            // Only the full state mask is a listed encoding
            if (m == `PESD_MASK_MESI) begin
              inc = one(l2_fetch & ~l2_fetch_uc & ~l2_fetch_tmiss);
            end
          end
          `PESD_EV_MEM_REF: begin
            // 80-bit accesses split in two, so they count double
            if (mem_ref_io) begin
              inc = 4'h0;
            end else if (mem_ref_fp80) begin
              inc = {1'b0, mem_ref_cnt, 1'b0};
            end else begin
              inc = {2'h0, mem_ref_cnt};
            end
          end
          `PESD_EV_L1_ALLOC: begin
            inc = one(l1_alloc);
          end
          `PESD_EV_L1_DALLOC: begin
            inc = one(l1_dirty_alloc);
          end
          `PESD_EV_L1_DEVICT: begin
            // Snoop, intervention and replacement all arrive here
            inc = one(l1_dirty_evict);
          end
          `PESD_EV_L1_PEND: begin
            // Weighted: adds the outstanding count every cycle
            inc = l1_miss_pend;
          end
          `PESD_EV_FETCH: begin
            inc = one(fetch);
          end
          `PESD_EV_FETCH_MISS: begin
            inc = one(fetch_miss);
          end
          `PESD_EV_ITRANS_MISS: begin
            inc = one(itrans_miss);
          end
          `PESD_EV_FETCH_STALL: begin
            inc = one(fetch_stall);
          end
          `PESD_EV_LDEC_STALL: begin
            inc = one(ldec_stall);
          end
          default: begin
            // Branch codes form one contiguous run
            if (code >= `PESD_EV_BR_FIRST && code <= `PESD_EV_BR_LAST) begin
              inc = one(br_ev[br_idx[3:0]]);
            end else begin
              // Reserved code: counts nothing, flagged in status
              unl = 1'b1;
            end
          end
        endcase
      end

      assign inc_all[4*g+3:4*g] = inc;
      assign unl_all[g] = unl;

      // Select register
      pesd_evsel #(
        .WMASK(`PESD_SEL_WMASK)
      ) u_sel (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(fire & pwrite & aligned & (paddr == off_sel)),
        .wr_data(pwdata),
        .sel_reg(sel_all[32*g+31:32*g])
      );

      // Counter proper
      pesd_counter #(
        .W(32)
      ) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .cnt_en(en_b),
        .edge_mode(edge_b),
        .inc(inc),
        .wr_en(fire & pwrite & aligned & (paddr == off_cnt)),
        .wr_data(pwdata),
        .cnt_reg(cnt_all[32*g+31:32*g])
      );
    end
  endgenerate

  // Status capture, one cycle behind the events
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg <= {NCNT{1'b0}};
      unl_reg <= {NCNT{1'b0}};
    end else begin
      act_reg <= {|inc_all[7:4], |inc_all[3:0]};
      unl_reg <= unl_all;
    end
  end

  // Read decode; unknown offsets answer with an error
  reg [31:0] rd_next; // Read data for this address
  reg err_next; // Address is unmapped
  always @* begin
    rd_next = 32'h00000000;
    err_next = 1'b0;
    if (!aligned) begin
      err_next = 1'b1;
    end else begin
      case (paddr)
        `PESD_OFF_EVSEL0: rd_next = sel_all[31:0];
        `PESD_OFF_EVSEL1: rd_next = sel_all[63:32];
        `PESD_OFF_CNT0: rd_next = cnt_all[31:0];
        `PESD_OFF_CNT1: rd_next = cnt_all[63:32];
        `PESD_OFF_STAT: rd_next = {28'h0000000, unl_reg, act_reg};
        default: err_next = 1'b1;
      endcase
    end
  end

  // APB answer: one wait state, data sampled in first access cycle
  // Keeps the read mux off the pready path at the cost of a cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup_acc) begin
      pready <= 1'b1;
      pslverr <= err_next;
      prdata <= pwrite ? 32'h00000000 : rd_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

endmodule // pesd_top

/* dv/pesd_properties.sv */
`timescale 1ns/1ps
`include "pesd_consts.vh"
// Watches the register port and the two counter outputs of the top level
module pesd_checker (
  input logic pclk, // Core clock
  input logic presetn, // Async reset, active low
  input logic psel, // APB select
  input logic penable, // APB access phase
  input logic pwrite, // APB direction
  input logic [7:0] paddr, // APB byte address
  input logic [31:0] prdata, // APB read data
  input logic pready, // APB ready
  input logic pslverr, // APB error
  input logic [31:0] cnt0, // Counter 0 value
  input logic [31:0] cnt1 // Counter 1 value
);
  // Register hit; only meaningful while the master holds an access
  logic mapped;
  assign mapped = paddr == `PESD_OFF_EVSEL0 || paddr == `PESD_OFF_EVSEL1
    || paddr == `PESD_OFF_CNT0 || paddr == `PESD_OFF_CNT1 || paddr == `PESD_OFF_STAT;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_late:
    assert property (psel && !penable |=> !pready) else $error("ready in first access cycle");
  chk_ready_second:
    assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("ready missing in second access cycle");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held longer than one cycle");
  chk_data_idle:
    assert property (!pready |-> prdata == 32'h00000000) else $error("read data outside ready");
  chk_err_unmapped:
    assert property (pready && !mapped |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  chk_err_mapped:
    assert property (pready && mapped |-> !pslverr) else $error("mapped access refused");
  chk_err_lone:
    assert property (pslverr |-> pready) else $error("error without ready");
  // A cycle adds at most fifteen; larger jumps only come from software writes
  chk_count_step:
    assert property (!(pready && pwrite) |=> (cnt0 - $past(cnt0)) <= 32'h0000000F
      && (cnt1 - $past(cnt1)) <= 32'h0000000F) else $error("counter jumped");
  chk_reset_clear:
    assert property ($rose(presetn) |-> cnt0 == 32'h00000000 && cnt1 == 32'h00000000
      && !pready) else $error("state not cleared by reset");
  cov_refused: cover property (pready && pslverr);
  cov_write: cover property (pready && pwrite);
  cov_count: cover property (!$past(pready) && cnt0 != $past(cnt0));
endmodule // pesd_checker
bind pesd_top pesd_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .cnt0, .cnt1);

/* dv/pesd_top_tb.sv */
`timescale 1ns/1ps
`include "pesd_consts.vh"
// Programs a selection, drives one condition, then reads the counter back
module pesd_top_tb;
  logic pclk, presetn, psel, penable, pwrite; // Clock, reset, APB controls
  logic [7:0] paddr; // APB address
  logic [31:0] pwdata, prdata, cnt0, cnt1; // APB data and counters
  logic pready, pslverr; // APB answer
  logic pstate_trans, pstate_freq, thermal_trip, core_halted; // Power conditions
  logic [12:0] br_ev, sb; // Branch pulses; single-bit events in table order
  logic [1:0] uop_cnt, fused_ret, mem_ref_cnt; // Small counts
  logic [3:0] vec_ret, vec_comp, l2_state, l1_miss_pend; // Vector, state, pending
  logic l2_load, l2_load_excl, l2_alloc, l2_evict, l2_dirty_evict, l2_hwpf; // L2 side
  logic l2_fetch, l2_fetch_uc, l2_fetch_tmiss, mem_ref_fp80, mem_ref_io; // Fetch, refs
  int err_total, tests_run; // Mismatches and comparisons
  // Codes of the single-bit events, index matches sb
  localparam logic [7:0] SC [13] = '{8'hCE, 8'hD3, 8'hDB, 8'hF0, 8'hF8, 8'h45, 8'h46,
    8'h47, 8'h80, 8'h81, 8'h85, 8'h86, 8'h87};
  pesd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pstate_trans, .pstate_freq, .thermal_trip, .core_halted, .br_ev,
    .packed_int_ret(sb[0]), .sync_uop(sb[1]), .uop_cnt, .fused_ret, .unfusion(sb[2]),
    .vec_ret, .vec_comp, .pf_up(sb[3]), .pf_dn(sb[4]), .l2_load, .l2_load_excl, .l2_alloc,
    .l2_evict, .l2_dirty_evict, .l2_state, .l2_hwpf, .l2_fetch, .l2_fetch_uc,
    .l2_fetch_tmiss, .mem_ref_cnt, .mem_ref_fp80, .mem_ref_io, .l1_alloc(sb[5]),
    .l1_dirty_alloc(sb[6]), .l1_dirty_evict(sb[7]), .l1_miss_pend, .fetch(sb[8]),
    .fetch_miss(sb[9]), .itrans_miss(sb[10]), .fetch_stall(sb[11]), .ldec_stall(sb[12]),
    .cnt0, .cnt1);
  // 50 MHz core clock
  always #10 pclk = ~pclk;
  // Verdict in one place
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // All conditions quiet; core halted so the active-cycle event stays still
  task idle;
    {core_halted, pstate_trans, pstate_freq, thermal_trip, br_ev, sb, uop_cnt, fused_ret,
      vec_ret, vec_comp, l2_load, l2_load_excl, l2_alloc, l2_evict, l2_dirty_evict,
      l2_state, l2_hwpf, l2_fetch, l2_fetch_uc, l2_fetch_tmiss, mem_ref_cnt, mem_ref_fp80,
      mem_ref_io, l1_miss_pend} <= {1'b1, 62'h0};
  endtask
  // One APB transfer; request held until ready is sampled, bounded wait
  task apb(input logic wr_i, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] d, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_i;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end else begin
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask
  // Clear counter 0 and enable the selection
  task go(input logic [7:0] code, input logic [7:0] mask, input logic edg);
    wr(`PESD_OFF_CNT0, 32'h00000000);
    wr(`PESD_OFF_EVSEL0, {8'h00, 1'b1, edg, 6'h00, mask, code});
  endtask
  // Hold the driven condition n cycles, stop, then read the count
  task cnt_chk(input int n, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    repeat (n) @(posedge pclk);
    idle();
    wr(`PESD_OFF_EVSEL0, 32'h00000000);
    apb(1'b0, `PESD_OFF_CNT0, 32'h0, d, e);
    check(d, exp);
  endtask
  // L2 event with its own strobe and the shared qualifiers
  task l2(input logic [7:0] code, mask, input logic [3:0] st, input logic hw, ex,
          input logic [31:0] exp);
    go(code, mask, 1'b0);
    l2_state <= st;
    l2_hwpf <= hw;
    l2_load_excl <= ex;
    l2_load <= code == 8'h29;
    l2_alloc <= code == 8'h24;
    l2_evict <= code == 8'h26;
    l2_dirty_evict <= code == 8'h27;
    cnt_chk(2, exp);
  endtask
  initial begin
    logic [31:0] v;
    logic er;
    err_total = 0;
    tests_run = 0;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    idle();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of selects and counters
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, v, er);
      check(v, 32'h00000000);
    end
    // Unmapped and unaligned places are refused
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 8'h02 : 8'h14, 32'h0, v, er);
      check({v[30:0], er}, 32'h00000001);
    end
    // Only writable select bits stick; an unlisted code is flagged
    wr(`PESD_OFF_EVSEL1, 32'hFFFFFFFF);
    apb(1'b0, `PESD_OFF_EVSEL1, 32'h0, v, er);
    check(v, `PESD_SEL_WMASK);
    apb(1'b0, `PESD_OFF_STAT, 32'h0, v, er);
    check({31'h0, v[3]}, 32'h00000001);
    wr(`PESD_OFF_EVSEL1, 32'h00000000);
    wr(`PESD_OFF_CNT1, 32'h1234ABCD);
    apb(1'b0, `PESD_OFF_CNT1, 32'h0, v, er);
    check(v, 32'h1234ABCD);
    check(cnt1, 32'h1234ABCD);
    // Counter 1 counts on its own select, on from the loaded value
    wr(`PESD_OFF_EVSEL1, 32'h00800080);
    sb <= 13'h0100;
    repeat (2) @(posedge pclk);
    idle();
    wr(`PESD_OFF_EVSEL1, 32'h00000000);
    apb(1'b0, `PESD_OFF_CNT1, 32'h0, v, er);
    check(v, 32'h1234ABCF);
    // A selected event ignores the branch pulses and the other single-bit events
    go(8'h80, 8'h00, 1'b0);
    {br_ev, sb} <= {13'h1FFF, 13'h1EFF};
    cnt_chk(2, 0);
    go(8'h58, 8'h00, 1'b0);
    pstate_trans <= 1'b1;
    cnt_chk(3, 3);
    go(8'h58, 8'h02, 1'b0);
    pstate_trans <= 1'b1;
    cnt_chk(3, 0);
    go(8'h58, 8'h02, 1'b0);
    {pstate_trans, pstate_freq} <= 2'h3;
    cnt_chk(3, 3);
    go(8'h59, 8'h00, 1'b0);
    thermal_trip <= 1'b1;
    cnt_chk(4, 4);
    go(8'h59, 8'h00, 1'b1);
    thermal_trip <= 1'b1;
    cnt_chk(4, 1);
    go(8'h79, 8'h00, 1'b0);
    core_halted <= 1'b0;
    cnt_chk(5, 5);
    go(8'h79, 8'h00, 1'b0);
    {core_halted, thermal_trip} <= 2'h1;
    cnt_chk(5, 0);
    for (int i = 0; i < 13; i++) begin
      go(8'h88 + 8'(i), 8'h00, 1'b0);
      br_ev <= 13'h0001 << i;
      cnt_chk(2, 2);
      go(SC[i], 8'h00, 1'b0);
      sb <= 13'h0001 << i;
      cnt_chk(2, 2);
    end
    go(8'hD7, 8'h00, 1'b0);
    uop_cnt <= 2'h3;
    cnt_chk(2, 6);
    go(8'hDA, 8'h00, 1'b0);
    fused_ret <= 2'h1;
    cnt_chk(2, 2);
    go(8'hDA, 8'h01, 1'b0);
    fused_ret <= 2'h2;
    cnt_chk(2, 0);
    go(8'hDA, 8'h02, 1'b0);
    fused_ret <= 2'h2;
    cnt_chk(2, 2);
    for (int m = 0; m < 4; m++) begin
      go(8'hD8, 8'(m), 1'b0);
      vec_ret <= 4'h1 << m;
      cnt_chk(2, 2);
      go(8'hD9, 8'(m), 1'b0);
      vec_comp <= 4'h1 << m;
      cnt_chk(2, 2);
    end
    go(8'hD8, 8'h00, 1'b0);
    vec_ret <= 4'h2;
    cnt_chk(2, 2);
    go(8'hD9, 8'h00, 1'b0);
    vec_comp <= 4'h2;
    cnt_chk(2, 0);
    l2(8'h29, 8'h0F, 4'h2, 1'b0, 1'b0, 2);
    l2(8'h29, 8'h0F, 4'h2, 1'b0, 1'b1, 0);
    l2(8'h24, 8'h02, 4'h4, 1'b0, 1'b0, 0);
    l2(8'h24, 8'h02, 4'h2, 1'b0, 1'b0, 2);
    l2(8'h26, 8'h08, 4'h8, 1'b1, 1'b0, 0);
    l2(8'h27, 8'h18, 4'h8, 1'b1, 1'b0, 2);
    l2(8'h27, 8'h18, 4'h8, 1'b0, 1'b0, 0);
    l2(8'h26, 8'h21, 4'h1, 1'b1, 1'b0, 2);
    l2(8'h24, 8'h31, 4'h1, 1'b0, 1'b0, 2);
    go(8'h28, 8'h0F, 1'b0);
    l2_fetch <= 1'b1;
    cnt_chk(2, 2);
    go(8'h28, 8'h0F, 1'b0);
    {l2_fetch, l2_fetch_uc} <= 2'h3;
    cnt_chk(2, 0);
    go(8'h28, 8'h0F, 1'b0);
    {l2_fetch, l2_fetch_tmiss} <= 2'h3;
    cnt_chk(2, 0);
    go(8'h43, 8'h00, 1'b0);
    mem_ref_cnt <= 2'h2;
    cnt_chk(2, 4);
    go(8'h43, 8'h00, 1'b0);
    {mem_ref_cnt, mem_ref_fp80} <= 3'h5;
    cnt_chk(2, 8);
    go(8'h43, 8'h00, 1'b0);
    {mem_ref_cnt, mem_ref_io} <= 3'h5;
    cnt_chk(2, 0);
    go(8'h48, 8'h00, 1'b0);
    l1_miss_pend <= 4'h5;
    cnt_chk(3, 15);
    // Reset in mid-count clears the counter
    go(8'h80, 8'h00, 1'b0);
    sb <= 13'h0100;
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    idle();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(cnt0, 32'h00000000);
    complete_run();
  end
endmodule // pesd_top_tb
